// ==== core/hfrx_cfg_regs.sv ====
// receiver configuration register bank with apb slave and squelch timing
//
// Notes on behaviour
// (RULE_01) low-power bit selects low-power receiver
// (RULE_02) lf enable feeds lf; split selects routing
// (RULE_03) agc over first pulses or whole frame
// (RULE_04) algorithm bit: preset clear, reset set
// (RULE_05) dynamic squelch from 18.88us to mask end
// (RULE_06) mixer clock source; single-ended forces internal
// (RULE_07) first-stage gain codes: full, cut, boost
// (RULE_08) clip bit limits first two stages
// (RULE_09) peer gain bit forces -6 dB window
// (RULE_10) host restarts receiver after clearing peer bit
// (RULE_11) later-stage gain codes limited to 0h..ah
// (RULE_12) reset-gain command loads later gain downstream
// (RULE_13) defaults at power-up and set-default command
// (RULE_14) mask timer in 64-carrier-period steps
// (RULE_15) registers read back last written value
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module hfrx_cfg_regs
    import hfrx_cfg_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [9:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic tx_end_in,
    input wire logic single_ended_in,
    output logic low_power_receive_out,
    output logic lf_to_amp_out,
    output logic lf_to_phase_out,
    output logic lf_differential_out,
    output logic agc_enable_out,
    output logic agc_full_period_out,
    output logic agc_reset_alg_out,
    output logic squelch_active_out,
    output logic rx_masked_out,
    output logic mixer_internal_out,
    output logic [2:0] amp_first_stage_gain_out,
    output logic [2:0] phase_first_stage_gain_out,
    output logic clip_out,
    output logic max_window_out,
    output logic [3:0] amp_later_stage_gain_out,
    output logic [3:0] phase_later_stage_gain_out
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] receiver_config_b_reg;
    logic [7:0] receiver_first_stage_gain_reg;
    logic [7:0] receiver_later_stage_gain_reg;
    logic [7:0] mask_timer_reg;
    logic [7:0] loaded_gain_reg;
    logic sys_tx_end_meta_reg;
    logic sys_tx_end_reg;
    logic tx_end_prev_reg;
    logic se_meta_reg;
    logic se_reg;
    logic [15:0] mask_cnt_reg;
    logic [7:0] step_cnt_reg;
    logic [7:0] mask_steps_reg;
    logic [15:0] sq_cnt_reg;
    logic cmd_seen_reg;

    // apb decode helpers
    logic wr_en;
    logic access;
    logic [7:0] idx;
    logic cmd_default;
    logic cmd_gain;

    // byte address is four times the printed index
    function automatic logic [9:0] hfrx_addr(input logic [7:0] index);
        hfrx_addr = {index, 2'b00};
    endfunction : hfrx_addr

    // clamps a later-stage code into the usable range
    function automatic logic [3:0] hfrx_clamp(input logic [3:0] code);
        hfrx_clamp = (code > HFRX_LATER_GAIN_MAX) ? HFRX_LATER_GAIN_MAX : code;
    endfunction : hfrx_clamp

    assign access = psel_in && penable_in;
    assign wr_en = access && pwrite_in;
    assign idx = paddr_in[9:2];
    assign cmd_default = wr_en && (paddr_in == hfrx_addr(HFRX_IDX_COMMAND))
        && pwdata_in[HFRX_BIT_CMD_SET_DEFAULT];
    assign cmd_gain = wr_en && (paddr_in == hfrx_addr(HFRX_IDX_COMMAND))
        && pwdata_in[HFRX_BIT_CMD_RESET_GAIN];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sys_tx_end_meta_reg <= 1'b0;
            sys_tx_end_reg <= 1'b0;
            tx_end_prev_reg <= 1'b0;
            se_meta_reg <= 1'b0;
            se_reg <= 1'b0;
        end else begin
            sys_tx_end_meta_reg <= tx_end_in;
            sys_tx_end_reg <= sys_tx_end_meta_reg;
            tx_end_prev_reg <= sys_tx_end_reg;
            se_meta_reg <= single_ended_in;
            se_reg <= se_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // configuration registers; set-default reloads every one
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cmd_default) begin
            receiver_config_b_reg <= HFRX_RST_CONFIG_B; // RULE_13
            receiver_first_stage_gain_reg <= HFRX_RST_FIRST_GAIN; // RULE_13
            receiver_later_stage_gain_reg <= HFRX_RST_LATER_GAIN; // RULE_13
            mask_timer_reg <= HFRX_RST_MASK_TIMER; // RULE_13
        end else if (wr_en) begin
            // whole bytes only; upper data bits are dropped
            if (idx == HFRX_IDX_CONFIG_B) begin
                receiver_config_b_reg <= pwdata_in[7:0]; // RULE_15
            end else if (idx == HFRX_IDX_FIRST_GAIN) begin
                receiver_first_stage_gain_reg <= pwdata_in[7:0]; // RULE_15
            end else if (idx == HFRX_IDX_LATER_GAIN) begin
                receiver_later_stage_gain_reg <= pwdata_in[7:0]; // RULE_15
            end else if (idx == HFRX_IDX_MASK_TIMER) begin
                mask_timer_reg <= pwdata_in[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // gain load: a plain write does not reach the later-stage gain outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            loaded_gain_reg <= HFRX_RST_LATER_GAIN;
            cmd_seen_reg <= 1'b0;
        end else begin
            cmd_seen_reg <= cmd_gain;
            if (cmd_gain) begin
                loaded_gain_reg <= receiver_later_stage_gain_reg; // RULE_12
            end
        end
    end

    // ------------------------------------------------------------
    // apb read path, zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            if (psel_in && !penable_in) begin
                if (idx == HFRX_IDX_CONFIG_B) begin
                    prdata_out <= {24'h00_0000, receiver_config_b_reg}; // RULE_15
                end else if (idx == HFRX_IDX_FIRST_GAIN) begin
                    prdata_out <= {24'h00_0000, receiver_first_stage_gain_reg}; // RULE_15
                end else if (idx == HFRX_IDX_LATER_GAIN) begin
                    prdata_out <= {24'h00_0000, receiver_later_stage_gain_reg}; // RULE_15
                end else if (idx == HFRX_IDX_MASK_TIMER) begin
                    prdata_out <= {24'h00_0000, mask_timer_reg};
                end else if (idx == HFRX_IDX_STATUS) begin
                    prdata_out <= {28'h000_0000, loaded_gain_reg[7:4] == 4'h0,
                        rx_masked_out, squelch_active_out, cmd_seen_reg};
                end else if (idx != HFRX_IDX_COMMAND) begin
                    pslverr_out <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // mask receive timer: counts 64-carrier steps after tx end
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mask_cnt_reg <= 16'h0000;
            step_cnt_reg <= 8'h00;
            mask_steps_reg <= 8'h00;
        end else if (sys_tx_end_reg && !tx_end_prev_reg) begin
            // codes below 4 behave as 4 steps
            mask_steps_reg <= (mask_timer_reg < 8'h04) ? 8'h04 : mask_timer_reg; // RULE_14
            step_cnt_reg <= 8'h00;
            mask_cnt_reg <= 16'h0001;
        end else if (mask_cnt_reg != 16'h0000) begin
            if (step_cnt_reg == 8'(HFRX_MASK_STEP_CYC - 1)) begin
                step_cnt_reg <= 8'h00;
                if (mask_cnt_reg[7:0] >= mask_steps_reg) begin
                    mask_cnt_reg <= 16'h0000; // RULE_14
                end else begin
                    mask_cnt_reg <= mask_cnt_reg + 16'h0001;
                end
            end else begin
                step_cnt_reg <= step_cnt_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // squelch delay counter from tx end
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sq_cnt_reg <= 16'h0000;
        end else if (sys_tx_end_reg && !tx_end_prev_reg) begin
            sq_cnt_reg <= 16'h0001;
        end else if (mask_cnt_reg == 16'h0000) begin
            sq_cnt_reg <= 16'h0000;
        end else if (sq_cnt_reg != 16'hffff) begin
            sq_cnt_reg <= sq_cnt_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // analog control outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            low_power_receive_out <= 1'b0;
            lf_to_amp_out <= 1'b0;
            lf_to_phase_out <= 1'b0;
            lf_differential_out <= 1'b0;
            agc_enable_out <= 1'b0;
            agc_full_period_out <= 1'b0;
            agc_reset_alg_out <= 1'b0;
            squelch_active_out <= 1'b0;
            rx_masked_out <= 1'b0;
            mixer_internal_out <= 1'b0;
            amp_first_stage_gain_out <= 3'h0;
            phase_first_stage_gain_out <= 3'h0;
            clip_out <= 1'b0;
            max_window_out <= 1'b0;
            amp_later_stage_gain_out <= 4'h0;
            phase_later_stage_gain_out <= 4'h0;
        end else begin
            low_power_receive_out <= receiver_config_b_reg[HFRX_BIT_LOW_POWER]; // RULE_01
            lf_differential_out <= receiver_config_b_reg[HFRX_BIT_LF_ENABLE]
                && !receiver_config_b_reg[HFRX_BIT_LF_SPLIT]; // RULE_02
            lf_to_amp_out <= receiver_config_b_reg[HFRX_BIT_LF_ENABLE]
                && receiver_config_b_reg[HFRX_BIT_LF_SPLIT]; // RULE_02
            lf_to_phase_out <= receiver_config_b_reg[HFRX_BIT_LF_ENABLE]
                && receiver_config_b_reg[HFRX_BIT_LF_SPLIT]; // RULE_02
            agc_enable_out <= receiver_config_b_reg[HFRX_BIT_AGC_ENABLE]; // RULE_03
            agc_full_period_out <= receiver_config_b_reg[HFRX_BIT_AGC_MODE]; // RULE_03
            agc_reset_alg_out <= receiver_config_b_reg[HFRX_BIT_AGC_ALG]; // RULE_04
            // squelch only between delay and mask expiry
            squelch_active_out <= receiver_config_b_reg[HFRX_BIT_SQUELCH_DYN]
                && (mask_cnt_reg != 16'h0000)
                && (sq_cnt_reg >= 16'(HFRX_SQUELCH_DELAY_CYC)); // RULE_05
            rx_masked_out <= (mask_cnt_reg != 16'h0000); // RULE_14
            mixer_internal_out <= receiver_config_b_reg[HFRX_BIT_MIXER_CLK] || se_reg; // RULE_06
            amp_first_stage_gain_out <= receiver_first_stage_gain_reg[7:5]; // RULE_07
            phase_first_stage_gain_out <= receiver_first_stage_gain_reg[4:2]; // RULE_07
            clip_out <= receiver_first_stage_gain_reg[HFRX_BIT_CLIP]; // RULE_08
            max_window_out <= receiver_first_stage_gain_reg[HFRX_BIT_PEER_GAIN]; // RULE_09
            // peer mode overrides the loaded codes; after clearing it the host
            // restarts the receiver (RULE_10)
            if (receiver_first_stage_gain_reg[HFRX_BIT_PEER_GAIN]) begin
                amp_later_stage_gain_out <= HFRX_PEER_LATER_GAIN; // RULE_09
                phase_later_stage_gain_out <= HFRX_PEER_LATER_GAIN; // RULE_09
            end else begin
                amp_later_stage_gain_out <= hfrx_clamp(loaded_gain_reg[7:4]); // RULE_11
                phase_later_stage_gain_out <= hfrx_clamp(loaded_gain_reg[3:0]); // RULE_11
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_low_power_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rst_in) |->
        low_power_receive_out == $past(receiver_config_b_reg[HFRX_BIT_LOW_POWER]))
        else $error("low power output wrong"); // RULE_01
    chk_lf_routing: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(lf_differential_out && lf_to_amp_out))
        else $error("lf routing conflict"); // RULE_02
    chk_agc_mode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(receiver_config_b_reg[HFRX_BIT_AGC_MODE]) |=> agc_full_period_out)
        else $error("agc mode not applied"); // RULE_03
    chk_agc_alg: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $changed(receiver_config_b_reg) |=> agc_reset_alg_out ==
        $past(receiver_config_b_reg[HFRX_BIT_AGC_ALG]))
        else $error("agc algorithm wrong"); // RULE_04
    chk_squelch_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys_tx_end_reg && !tx_end_prev_reg) |=> !squelch_active_out [*1])
        else $error("squelch too early"); // RULE_05
    chk_mixer_single: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(se_reg) |-> mixer_internal_out)
        else $error("mixer not internal in single mode"); // RULE_06
    chk_first_gain: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rst_in) |->
        amp_first_stage_gain_out == $past(receiver_first_stage_gain_reg[7:5]))
        else $error("first stage gain wrong"); // RULE_07
    chk_clip_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rst_in) |->
        clip_out == $past(receiver_first_stage_gain_reg[HFRX_BIT_CLIP]))
        else $error("clip output wrong"); // RULE_08
    chk_peer_force: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(receiver_first_stage_gain_reg[HFRX_BIT_PEER_GAIN]) |->
        (amp_later_stage_gain_out == HFRX_PEER_LATER_GAIN) && max_window_out)
        else $error("peer gain not forced"); // RULE_09
    chk_later_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        amp_later_stage_gain_out <= HFRX_LATER_GAIN_MAX)
        else $error("later gain out of range"); // RULE_11
    chk_gain_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!cmd_gain && !$past(cmd_gain)) |-> $stable(loaded_gain_reg))
        else $error("gain loaded without command"); // RULE_12
    chk_default_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        cmd_default |=> receiver_config_b_reg == HFRX_RST_CONFIG_B)
        else $error("default not loaded"); // RULE_13
    chk_mask_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys_tx_end_reg && !tx_end_prev_reg) |=> ##1 rx_masked_out)
        else $error("mask not started"); // RULE_14
    chk_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_en && idx == HFRX_IDX_CONFIG_B && !cmd_default) |=>
        receiver_config_b_reg == $past(pwdata_in[7:0]))
        else $error("readback mismatch"); // RULE_15
endmodule : hfrx_cfg_regs
`default_nettype wire

// ==== core/hfrx_cfg_pkg.sv ====
// constants for the receiver configuration register bank
package hfrx_cfg_pkg;
    // ------------------------------------------------------------
    // register offsets (printed offsets are word indices, not byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HFRX_IDX_CONFIG_B = 8'h0b;
    localparam logic [7:0] HFRX_IDX_FIRST_GAIN = 8'h0c;
    localparam logic [7:0] HFRX_IDX_LATER_GAIN = 8'h0d;
    localparam logic [7:0] HFRX_IDX_MASK_TIMER = 8'h0e;
    localparam logic [7:0] HFRX_IDX_COMMAND = 8'h20;
    localparam logic [7:0] HFRX_IDX_STATUS = 8'h21;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HFRX_RST_CONFIG_B = 8'h1a;
    localparam logic [7:0] HFRX_RST_FIRST_GAIN = 8'hd8;
    localparam logic [7:0] HFRX_RST_LATER_GAIN = 8'h00;
    localparam logic [7:0] HFRX_RST_MASK_TIMER = 8'h08;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HFRX_BIT_LOW_POWER = 7;
    localparam int HFRX_BIT_LF_SPLIT = 6;
    localparam int HFRX_BIT_LF_ENABLE = 5;
    localparam int HFRX_BIT_AGC_ENABLE = 4;
    localparam int HFRX_BIT_AGC_MODE = 3;
    localparam int HFRX_BIT_AGC_ALG = 2;
    localparam int HFRX_BIT_SQUELCH_DYN = 1;
    localparam int HFRX_BIT_MIXER_CLK = 0;
    localparam int HFRX_BIT_CLIP = 1;
    localparam int HFRX_BIT_PEER_GAIN = 0;
    localparam int HFRX_BIT_CMD_SET_DEFAULT = 0;
    localparam int HFRX_BIT_CMD_RESET_GAIN = 1;
    localparam logic [3:0] HFRX_LATER_GAIN_MAX = 4'ha;
    localparam logic [3:0] HFRX_PEER_LATER_GAIN = 4'h2;
    // ------------------------------------------------------------
    // timing: times in ps, turned into whole sys clock cycles
    // ------------------------------------------------------------
    localparam int HFRX_CLK_PERIOD_NS = 20;
    localparam int HFRX_SQUELCH_DELAY_PS = 18880000;
    localparam int HFRX_SQUELCH_DELAY_CYC =
        (HFRX_SQUELCH_DELAY_PS + HFRX_CLK_PERIOD_NS * 1000 - 1) / (HFRX_CLK_PERIOD_NS * 1000);
    localparam int HFRX_MASK_STEP_PS = 4720000;
    localparam int HFRX_MASK_STEP_CYC =
        (HFRX_MASK_STEP_PS / (HFRX_CLK_PERIOD_NS * 1000)) < 1 ? 1 :
        (HFRX_MASK_STEP_PS / (HFRX_CLK_PERIOD_NS * 1000));
endpackage : hfrx_cfg_pkg

// ==== dv/hfrx_host_model.sv ====
// host model: apb master plus transmitter-end and antenna-mode pins
`timescale 1ns/100ps
`default_nettype none
module hfrx_host_model (
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic [31:0] prdata_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [9:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic tx_end_out,
    output logic single_ended_out
);
    logic stuck;
    // --------------------------------------------------------
    // idle bus at time zero
    // --------------------------------------------------------
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 10'h155;
        pwdata_out = 32'h5a5a5a5a;
        tx_end_out = 1'b0;
        single_ended_out = 1'b0;
        stuck = 1'b0;
    end
    // one transfer; request held until pready is seen at a rising edge or 32 more edges pass
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        // sample at the rising edge itself; the slave's new values land after it
        @(posedge clk_in);
        while (pready_in !== 1'b1 && n < 32) begin
            n++;
            @(posedge clk_in);
        end
        if (n >= 32) stuck = 1'b1;
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // released lines show junk, never the last value
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask : xfer
    // pin levels change only just after a rising edge
    task automatic set_pins(input logic tx, input logic se);
        @(posedge clk_in);
        tx_end_out <= tx;
        single_ended_out <= se;
    endtask : set_pins
endmodule : hfrx_host_model
`default_nettype wire

// ==== dv/test_hf_receiver_config_regs.sv ====
// self-checking bench for the receiver configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_hf_receiver_config_regs;
    import hfrx_cfg_pkg::*;
    localparam logic [9:0] A_B = {HFRX_IDX_CONFIG_B, 2'b00};
    localparam logic [9:0] A_G1 = {HFRX_IDX_FIRST_GAIN, 2'b00};
    localparam logic [9:0] A_G2 = {HFRX_IDX_LATER_GAIN, 2'b00};
    localparam logic [9:0] A_M = {HFRX_IDX_MASK_TIMER, 2'b00};
    localparam logic [9:0] A_C = {HFRX_IDX_COMMAND, 2'b00};
    // masked output rises one cycle after detect, squelch is counted from detect
    localparam int SQ_DELAY = HFRX_SQUELCH_DELAY_CYC - 1;
    logic sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, tx_end, se;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, q_last;
    logic lp, lf_amp, lf_ph, lf_diff, agc_en, agc_full, agc_alg, sq, masked, mix, clip, maxw;
    logic [2:0] g1a, g1p;
    logic [3:0] g2a, g2p;
    int error_cnt = 0;
    int n_compared = 0;
    hfrx_cfg_regs dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .tx_end_in(tx_end),
        .single_ended_in(se), .low_power_receive_out(lp), .lf_to_amp_out(lf_amp),
        .lf_to_phase_out(lf_ph), .lf_differential_out(lf_diff), .agc_enable_out(agc_en),
        .agc_full_period_out(agc_full), .agc_reset_alg_out(agc_alg), .squelch_active_out(sq),
        .rx_masked_out(masked), .mixer_internal_out(mix), .amp_first_stage_gain_out(g1a),
        .phase_first_stage_gain_out(g1p), .clip_out(clip), .max_window_out(maxw),
        .amp_later_stage_gain_out(g2a), .phase_later_stage_gain_out(g2p));
    hfrx_host_model host_u (.clk_in(sys_clk_in), .pready_in(pready), .prdata_in(prdata),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .tx_end_out(tx_end), .single_ended_out(se));
    // --------------------------------------------------------
    // clock, verdict and comparison helpers
    // --------------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    // one bus access; a hung slave ends the run
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, input logic ee);
        logic e;
        host_u.xfer(w, a, {24'h0, d}, q_last, e);
        if (host_u.stuck === 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
        cmp({31'h0, e}, {31'h0, ee}, "slave error");
    endtask : acc
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00, 1'b0);
        cmp(q_last, {24'h0, exp}, "read data");
    endtask : rd
    // outputs lag the register by one edge, so look two cycles later
    task automatic chk_b(input logic [7:0] v, input logic s);
        repeat (2) @(negedge sys_clk_in);
        cmp({24'h0, lp, lf_amp, lf_ph, lf_diff, agc_en, agc_full, agc_alg, mix},
            {24'h0, v[7], v[6] & v[5], v[6] & v[5], v[5] & ~v[6], v[4], v[3], v[2], v[0] | s},
            "receive mode outputs");
    endtask : chk_b
    task automatic chk_g(input logic [7:0] v, input logic [3:0] a2, input logic [3:0] p2);
        repeat (2) @(negedge sys_clk_in);
        cmp({16'h0, g1a, g1p, clip, maxw, g2a, g2p}, {16'h0, v, a2, p2}, "gain outputs");
    endtask : chk_g
    // end of transmission, then time the mask window and squelch start
    task automatic mask_run(input logic [7:0] mrt, input int len_exp, input int sq_exp);
        int n, len, sqd;
        n = 0;
        len = 0;
        sqd = -1;
        acc(1'b1, A_M, mrt, 1'b0);
        host_u.set_pins(1'b1, 1'b0);
        while (masked !== 1'b1 && n < 20) begin
            n++;
            @(negedge sys_clk_in);
        end
        while (masked === 1'b1 && len < 4000) begin
            if (sq === 1'b1 && sqd < 0) sqd = len;
            len++;
            @(negedge sys_clk_in);
        end
        cmp(len, len_exp, "mask length");
        cmp(sqd, sq_exp, "squelch start");
        host_u.set_pins(1'b0, 1'b0);
    endtask : mask_run
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk_b(HFRX_RST_CONFIG_B, 1'b0);
        chk_g(HFRX_RST_FIRST_GAIN, 4'h0, 4'h0);
        rd(A_B, 8'h1a);
        rd(A_G1, 8'hd8);
        rd(A_G2, 8'h00);
        rd({HFRX_IDX_STATUS, 2'b00}, 8'h08);
        // every bit pattern class of the mode register
        for (int i = 0; i < 8; i++) begin
            logic [7:0] v;
            v = 8'h21 << i ^ {8{i[0]}};
            acc(1'b1, A_B, v, 1'b0);
            chk_b(v, 1'b0);
            rd(A_B, v);
        end
        acc(1'b1, A_B, 8'h00, 1'b0);
        host_u.set_pins(1'b0, 1'b1);
        repeat (4) @(posedge sys_clk_in);
        chk_b(8'h00, 1'b1);
        host_u.set_pins(1'b0, 1'b0);
        // all first-stage codes on both channels
        for (int i = 0; i < 8; i++) begin
            logic [7:0] v;
            v = {i[2:0], ~i[2:0], i[0], 1'b0};
            acc(1'b1, A_G1, v, 1'b0);
            chk_g(v, 4'h0, 4'h0);
            rd(A_G1, v);
        end
        // later-stage gain: no effect until loaded, then clamped
        for (int i = 0; i < 16; i++) begin
            logic [3:0] a, p, ea, ep;
            a = i[3:0];
            p = 4'hf - a;
            ea = (a > HFRX_LATER_GAIN_MAX) ? HFRX_LATER_GAIN_MAX : a;
            ep = (p > HFRX_LATER_GAIN_MAX) ? HFRX_LATER_GAIN_MAX : p;
            acc(1'b1, A_G2, {a, p}, 1'b0);
            rd(A_G2, {a, p});
            acc(1'b1, A_C, 8'h02, 1'b0);
            chk_g({3'd7, 3'd0, 2'b10}, ea, ep);
        end
        acc(1'b1, A_G2, 8'h33, 1'b0);
        chk_g({3'd7, 3'd0, 2'b10}, 4'ha, 4'h0);
        acc(1'b1, A_G1, 8'h01, 1'b0);
        chk_g(8'h01, HFRX_PEER_LATER_GAIN, HFRX_PEER_LATER_GAIN);
        acc(1'b1, A_G1, 8'h00, 1'b0);
        acc(1'b1, A_C, 8'h02, 1'b0);
        chk_g(8'h00, 4'h3, 4'h3);
        // squelch and mask timing, minimum mask, squelch disabled
        acc(1'b1, A_B, 8'h1a, 1'b0);
        mask_run(8'h08, 8 * HFRX_MASK_STEP_CYC, SQ_DELAY);
        mask_run(8'h02, 4 * HFRX_MASK_STEP_CYC, SQ_DELAY);
        acc(1'b1, A_B, 8'h18, 1'b0);
        mask_run(8'h08, 8 * HFRX_MASK_STEP_CYC, -1);
        // unmapped place and write-only command register
        acc(1'b1, 10'h3c, 8'hff, 1'b1);
        acc(1'b0, 10'h3c, 8'h00, 1'b1);
        rd(A_C, 8'h00);
        // set-default command reloads the four configuration registers
        acc(1'b1, A_B, 8'he5, 1'b0);
        acc(1'b1, A_G1, 8'h27, 1'b0);
        acc(1'b1, A_M, 8'h33, 1'b0);
        acc(1'b1, A_C, 8'h01, 1'b0);
        rd(A_B, HFRX_RST_CONFIG_B);
        rd(A_G1, HFRX_RST_FIRST_GAIN);
        rd(A_G2, HFRX_RST_LATER_GAIN);
        rd(A_M, HFRX_RST_MASK_TIMER);
        chk_b(HFRX_RST_CONFIG_B, 1'b0);
        tally_and_finish();
    end
    // watchdog against a hang anywhere
    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : test_hf_receiver_config_regs
`default_nettype wire
